/* rtl/alarm_flag_pkg.sv */
// constants, register map and helpers for the threshold alarm flag bank
// assumes one system clock domain for the flags and one link clock for the serial port
//
// Summary of operation
// - separate high and low flags, active plus tripped
// - active flag follows the live alarm condition
// - tripped flag latches until its register is read
// - flags live at addresses 11h through 14h
// - 11h holds tripped flags, channels 0 to 3
// - 12h holds active flags, channels 0 to 3
// - 13h holds tripped flags, channels 4 to 7
// - flag reads one on alarm, zero otherwise
// - flags read-only, all zero after reset
// - four-channel build ignores upper-channel writes
// - four-channel build reads upper registers as ones
// - 14h holds active flags, channels 4 to 7
// - 10h bit n ORs channel n tripped flags; four-channel build reads bits 4 to 7 as ones
package alarm_flag_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int NUM_CH_MAX = 8;
    localparam int HALF_CH = 4;

    // program register addresses
    localparam logic [ADDR_W-1:0] ADDR_SUMMARY = 7'h10;
    localparam logic [ADDR_W-1:0] ADDR_TRIP_LO = 7'h11;
    localparam logic [ADDR_W-1:0] ADDR_LIVE_LO = 7'h12;
    localparam logic [ADDR_W-1:0] ADDR_TRIP_HI = 7'h13;
    localparam logic [ADDR_W-1:0] ADDR_LIVE_HI = 7'h14;

    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ABSENT_READ = 8'hff;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // channel-indexed masks: bit n is channel n
    localparam logic [NUM_CH_MAX-1:0] CH_MASK_FULL = 8'hff;
    localparam logic [NUM_CH_MAX-1:0] CH_MASK_HALF = 8'h0f;
    localparam logic [NUM_CH_MAX-1:0] LOWER_CH = 8'h0f;
    localparam logic [NUM_CH_MAX-1:0] UPPER_CH = 8'hf0;

    typedef enum logic [0:0] {
        LINK_IDLE = 1'b0,
        LINK_WAIT = 1'b1
    } link_state_e;

    // four channels into one byte: low then high flag per channel, first channel on top
    function automatic logic [DATA_W-1:0] pack_pairs(input logic [HALF_CH-1:0] lo, input logic [HALF_CH-1:0] hi);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < HALF_CH; i++) begin
            r[DATA_W-1-2*i] = lo[i];
            r[DATA_W-2-2*i] = hi[i];
        end
        return r;
    endfunction : pack_pairs

endpackage : alarm_flag_pkg

/* rtl/alarm_link_port.sv */
// link-clock end of the register read path
// assumes the serial port logic gives a one-cycle request with a stable address on clk_link
`timescale 1ns/1ps

module alarm_link_port
    import alarm_flag_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    // link clock and reset
    input wire logic clk_link,
    input wire logic reset_n,
    // request from the serial port
    input wire logic req,
    input wire logic req_write,
    input wire logic [AW-1:0] addr,
    // from the system domain
    input wire logic ack_tog,
    input wire logic [DW-1:0] rd_word,
    // to the system domain
    output logic req_tog_r,
    output logic [AW-1:0] addr_hold_r,
    // answer to the serial port
    output logic [DW-1:0] rd_data_r,
    output logic rd_valid_r,
    output logic busy_r
);

    link_state_e state_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic done;

    always_ff @(posedge clk_link or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tog;
            ack_s2_r <= ack_s1_r;
        end
    end

    assign done = (ack_s2_r == req_tog_r);

    // writes never leave the link side, so no flag can be disturbed by one
    always_ff @(posedge clk_link or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= LINK_IDLE;
            busy_r <= 1'b0;
            req_tog_r <= 1'b0;
            addr_hold_r <= '0;
            rd_data_r <= FLAGS_RESET;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= 1'b0;
            case (state_r)
                LINK_IDLE: begin
                    if (req && !req_write) begin
                        addr_hold_r <= addr;
                        req_tog_r <= ~req_tog_r;
                        busy_r <= 1'b1;
                        state_r <= LINK_WAIT;
                    end
                end
                LINK_WAIT: begin
                    // rd_word is held still by the system side once ack has toggled
                    if (done) begin
                        rd_data_r <= rd_word;
                        rd_valid_r <= 1'b1;
                        busy_r <= 1'b0;
                        state_r <= LINK_IDLE;
                    end
                end
                default: begin
                    busy_r <= 1'b0;
                    state_r <= LINK_IDLE;
                end
            endcase
        end
    end

    write_ignored_a: assert property (
        @(posedge clk_link) disable iff (!reset_n)
        (!busy_r && req && req_write) |=> (!busy_r && $stable(req_tog_r) && $stable(addr_hold_r))
    ) else $error("write request started a transfer");

    addr_held_a: assert property (
        @(posedge clk_link) disable iff (!reset_n)
        (busy_r && $past(busy_r)) |-> ($stable(addr_hold_r) && $stable(req_tog_r))
    ) else $error("held address moved during a transfer");

    valid_after_wait_a: assert property (
        @(posedge clk_link) disable iff (!reset_n)
        rd_valid_r |-> ($past(busy_r) && !busy_r && (ack_s2_r == req_tog_r))
    ) else $error("read data flagged without a completed handshake");

endmodule : alarm_link_port

/* rtl/alarm_flag_bank.sv */
// threshold alarm flag bank: active and tripped flags per channel, read over the serial port
// assumes cond_high and cond_low come from the comparator on clk_sys; the port runs on clk_link
`timescale 1ns/1ps

module alarm_flag_bank
    import alarm_flag_pkg::*;
#(
    parameter int CHANNELS = NUM_CH_MAX
) (
    // system clock domain
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // comparator alarm levels, bit n is channel n
    input wire logic [NUM_CH_MAX-1:0] cond_high,
    input wire logic [NUM_CH_MAX-1:0] cond_low,
    // serial port side, link clock domain
    input wire logic clk_link,
    input wire logic link_req,
    input wire logic link_req_write,
    input wire logic [ADDR_W-1:0] link_addr,
    output logic [DATA_W-1:0] link_rd_data,
    output logic link_rd_valid,
    output logic link_busy,
    // level toward the alarm pin
    output logic alarm_any
);

    localparam bit FOUR_CH = (CHANNELS <= HALF_CH);
    localparam logic [NUM_CH_MAX-1:0] CH_MASK = FOUR_CH ? CH_MASK_HALF : CH_MASK_FULL;

    logic [NUM_CH_MAX-1:0] live_low_r;
    logic [NUM_CH_MAX-1:0] live_high_r;
    logic [NUM_CH_MAX-1:0] trip_low_r;
    logic [NUM_CH_MAX-1:0] trip_high_r;
    logic [NUM_CH_MAX-1:0] trip_low_nxt;
    logic [NUM_CH_MAX-1:0] trip_high_nxt;
    logic [NUM_CH_MAX-1:0] clr_mask;
    logic req_s1_r;
    logic req_s2_r;
    logic req_s3_r;
    logic rd_take;
    logic ack_tog_r;
    logic [DATA_W-1:0] rd_word_r;
    logic alarm_any_r;
    logic req_tog;
    logic [ADDR_W-1:0] addr_hold;

    // register read decode, used only by the capture; the checks work out their own values
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] a,
        input logic [NUM_CH_MAX-1:0] tl,
        input logic [NUM_CH_MAX-1:0] th,
        input logic [NUM_CH_MAX-1:0] ll,
        input logic [NUM_CH_MAX-1:0] lh
    );
        logic [DATA_W-1:0] w;
        w = UNMAPPED_READ;
        case (a)
            ADDR_SUMMARY: w = (tl | th) | (FOUR_CH ? UPPER_CH : '0);
            ADDR_TRIP_LO: w = pack_pairs(tl[HALF_CH-1:0], th[HALF_CH-1:0]);
            ADDR_LIVE_LO: w = pack_pairs(ll[HALF_CH-1:0], lh[HALF_CH-1:0]);
            ADDR_TRIP_HI: w = FOUR_CH ? ABSENT_READ
                : pack_pairs(tl[NUM_CH_MAX-1:HALF_CH], th[NUM_CH_MAX-1:HALF_CH]);
            ADDR_LIVE_HI: w = FOUR_CH ? ABSENT_READ
                : pack_pairs(ll[NUM_CH_MAX-1:HALF_CH], lh[NUM_CH_MAX-1:HALF_CH]);
            default: w = UNMAPPED_READ;
        endcase
        return w;
    endfunction : read_word

    // channels that the tripped register at this address covers
    function automatic logic [NUM_CH_MAX-1:0] trip_cover(input logic [ADDR_W-1:0] a);
        logic [NUM_CH_MAX-1:0] m;
        m = '0;
        case (a)
            ADDR_TRIP_LO: m = LOWER_CH;
            ADDR_TRIP_HI: m = FOUR_CH ? '0 : UPPER_CH;
            default: m = '0;
        endcase
        return m;
    endfunction : trip_cover

    alarm_link_port #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_link (
        .clk_link(clk_link),
        .reset_n(reset_n),
        .req(link_req),
        .req_write(link_req_write),
        .addr(link_addr),
        .ack_tog(ack_tog_r),
        .rd_word(rd_word_r),
        .req_tog_r(req_tog),
        .addr_hold_r(addr_hold),
        .rd_data_r(link_rd_data),
        .rd_valid_r(link_rd_valid),
        .busy_r(link_busy)
    );

    // active flags: a registered copy of the comparator levels
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            live_low_r <= FLAGS_RESET;
            live_high_r <= FLAGS_RESET;
        end else if (clk_en) begin
            live_low_r <= cond_low & CH_MASK;
            live_high_r <= cond_high & CH_MASK;
        end
    end

    // read request arrives as a toggle; the second and third stages feed the edge detect
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else if (clk_en) begin
            req_s1_r <= req_tog;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    assign rd_take = req_s2_r ^ req_s3_r;

    // a read clears the tripped flags it covers, at the moment the byte is captured
    always_comb begin
        clr_mask = rd_take ? trip_cover(addr_hold) : '0;
        trip_low_nxt = (trip_low_r & ~clr_mask) | (cond_low & CH_MASK);
        trip_high_nxt = (trip_high_r & ~clr_mask) | (cond_high & CH_MASK);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trip_low_r <= FLAGS_RESET;
            trip_high_r <= FLAGS_RESET;
        end else if (clk_en) begin
            trip_low_r <= trip_low_nxt;
            trip_high_r <= trip_high_nxt;
        end
    end

    // snapshot of the addressed byte; it stays still until the next request, so the
    // link side may copy it after seeing the ack
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_word_r <= FLAGS_RESET;
            ack_tog_r <= 1'b0;
        end else if (clk_en && rd_take) begin
            rd_word_r <= read_word(addr_hold, trip_low_r, trip_high_r, live_low_r, live_high_r);
            ack_tog_r <= ~ack_tog_r;
        end
    end

    // alarm pin level tracks any tripped flag, the cue for the host to read
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alarm_any_r <= 1'b0;
        end else if (clk_en) begin
            alarm_any_r <= |(trip_low_nxt | trip_high_nxt);
        end
    end

    assign alarm_any = alarm_any_r;

    reset_zero_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(reset_n) |-> (trip_low_r == '0 && trip_high_r == '0 && live_low_r == '0 && live_high_r == '0)
    ) else $error("flags not zero after reset");

    live_follow_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $past(clk_en) |->
            (live_low_r == ($past(cond_low) & CH_MASK) && live_high_r == ($past(cond_high) & CH_MASK))
    ) else $error("active flag does not follow its condition");

    trip_hold_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $past(clk_en) |->
            ((($past(trip_low_r) & ~$past(clr_mask)) & ~trip_low_r) == '0 &&
             (($past(trip_high_r) & ~$past(clr_mask)) & ~trip_high_r) == '0)
    ) else $error("tripped flag dropped without a read");

    trip_catch_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $past(clk_en) |->
            ((($past(cond_low) & CH_MASK) & ~trip_low_r) == '0 &&
             (($past(cond_high) & CH_MASK) & ~trip_high_r) == '0)
    ) else $error("alarm lost, possibly to a read clear");

    trip_source_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $past(clk_en) |->
            ((trip_low_r & ~$past(trip_low_r) & ~$past(cond_low)) == '0 &&
             (trip_high_r & ~$past(trip_high_r) & ~$past(cond_high)) == '0)
    ) else $error("tripped flag set with no alarm");

    trip_clear_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && rd_take && addr_hold == ADDR_TRIP_LO && cond_low == '0 && cond_high == '0)
            |=> (trip_low_r[HALF_CH-1:0] == '0 && trip_high_r[HALF_CH-1:0] == '0)
    ) else $error("tripped flags of channels 0 to 3 survive their read");

    trip_keep_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && rd_take && addr_hold == ADDR_TRIP_LO) |=>
            (trip_low_r[NUM_CH_MAX-1:HALF_CH] == ($past(trip_low_r[NUM_CH_MAX-1:HALF_CH]) |
             ($past(cond_low[NUM_CH_MAX-1:HALF_CH]) & CH_MASK[NUM_CH_MAX-1:HALF_CH])))
    ) else $error("read of channels 0 to 3 touched other channels");

    trip_lo_map_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && rd_take && addr_hold == ADDR_TRIP_LO) |=>
            (rd_word_r[7] == $past(trip_low_r[0]) && rd_word_r[6] == $past(trip_high_r[0]) &&
             rd_word_r[1] == $past(trip_low_r[3]) && rd_word_r[0] == $past(trip_high_r[3]))
    ) else $error("bit order wrong in tripped byte for channels 0 to 3");

    live_lo_map_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && rd_take && addr_hold == ADDR_LIVE_LO) |=>
            (rd_word_r[5] == $past(live_low_r[1]) && rd_word_r[4] == $past(live_high_r[1]) &&
             rd_word_r[3] == $past(live_low_r[2]) && rd_word_r[0] == $past(live_high_r[3]))
    ) else $error("bit order wrong in active byte for channels 0 to 3");

    trip_hi_map_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!FOUR_CH && clk_en && rd_take && addr_hold == ADDR_TRIP_HI) |=>
            (rd_word_r[7] == $past(trip_low_r[4]) && rd_word_r[6] == $past(trip_high_r[4]) &&
             rd_word_r[0] == $past(trip_high_r[7]))
    ) else $error("bit order wrong in tripped byte for channels 4 to 7");

    live_hi_map_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!FOUR_CH && clk_en && rd_take && addr_hold == ADDR_LIVE_HI) |=>
            (rd_word_r[7] == $past(live_low_r[4]) && rd_word_r[2] == $past(live_high_r[6]) &&
             rd_word_r[1] == $past(live_low_r[7]))
    ) else $error("bit order wrong in active byte for channels 4 to 7");

    absent_ones_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (FOUR_CH && clk_en && rd_take && (addr_hold == ADDR_TRIP_HI || addr_hold == ADDR_LIVE_HI))
            |=> (rd_word_r == ABSENT_READ)
    ) else $error("absent register did not read as all ones");

    summary_or_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && rd_take && addr_hold == ADDR_SUMMARY) |=>
            (rd_word_r[HALF_CH-1:0] == $past(trip_low_r[HALF_CH-1:0] | trip_high_r[HALF_CH-1:0]) &&
             rd_word_r[DATA_W-1:HALF_CH] == (FOUR_CH ? ABSENT_READ[DATA_W-1:HALF_CH] :
                 $past(trip_low_r[NUM_CH_MAX-1:HALF_CH] | trip_high_r[NUM_CH_MAX-1:HALF_CH])))
    ) else $error("summary bit is not the OR of its channel flags");

    upper_idle_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        FOUR_CH |-> ((trip_low_r | trip_high_r | live_low_r | live_high_r) & UPPER_CH) == '0
    ) else $error("absent channels hold a flag");

    ack_pair_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $past(clk_en) |-> ((ack_tog_r != $past(ack_tog_r)) == $past(rd_take))
    ) else $error("ack toggle not paired with a captured read");

    alarm_level_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        alarm_any_r == |(trip_low_r | trip_high_r)
    ) else $error("alarm level disagrees with tripped flags");

endmodule : alarm_flag_bank

/* verif/link_host_model.sv */
// host model of the serial register port: makes the link clock and issues one access at a time
// assumes the bank answers a read within a dozen link clocks and drops writes silently
`timescale 1ns/1ps

module link_host_model
    import alarm_flag_pkg::*;
(
    // link clock made by the host
    output logic clk_link,
    // request toward the bank
    output logic link_req,
    output logic link_req_write,
    output logic [ADDR_W-1:0] link_addr,
    // answer from the bank
    input wire logic [DATA_W-1:0] link_rd_data,
    input wire logic link_rd_valid,
    input wire logic link_busy
);
    logic run;

    // the clock parks low between frames, as a real host clock does
    initial begin
        clk_link = 1'b0;
        run = 1'b1;
        link_req = 1'b0;
        link_req_write = 1'b1;
        link_addr = 7'h55;
        #3;
        forever begin
            #62.5;
            if (run || clk_link) clk_link = ~clk_link;
        end
    end

    // ok: a read answered in time, or a write that left busy and valid low
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                          output logic ok);
        int n;
        run = 1'b1;
        repeat (2) @(posedge clk_link);
        link_req <= 1'b1;
        link_req_write <= wr;
        link_addr <= a;
        @(posedge clk_link);
        // released lines show the inverse so a stale value cannot pass
        link_req <= 1'b0;
        link_req_write <= ~wr;
        link_addr <= ~a;
        d = 8'h00;
        ok = wr;
        for (n = 0; n < 12; n++) begin
            @(posedge clk_link);
            if (wr && (link_busy !== 1'b0 || link_rd_valid !== 1'b0)) ok = 1'b0;
            if (!wr && link_rd_valid === 1'b1) begin
                d = link_rd_data;
                ok = 1'b1;
                break;
            end
        end
        @(posedge clk_link);
        run = 1'b0;
    endtask : access
endmodule : link_host_model

/* verif/test_alarm_flag_bank.sv */
// self-checking bench for the alarm flag bank, eight-channel and four-channel builds side by side
// assumes the host model answers each access; both builds share the comparator inputs
`timescale 1ns/1ps

module test_alarm_flag_bank;
    import alarm_flag_pkg::*;

    logic clk_sys, reset_n, clk_en;
    logic [NUM_CH_MAX-1:0] cond_high, cond_low;
    logic clk_link, link_req, link_req_write, link_rd_valid, link_busy, alarm_any;
    logic [ADDR_W-1:0] link_addr;
    logic [DATA_W-1:0] link_rd_data;
    logic clk_link4, link_req4, link_req_write4, link_rd_valid4, link_busy4, alarm_any4;
    logic [ADDR_W-1:0] link_addr4;
    logic [DATA_W-1:0] link_rd_data4;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    alarm_flag_bank #(.CHANNELS(8)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .cond_high(cond_high), .cond_low(cond_low),
        .clk_link(clk_link), .link_req(link_req), .link_req_write(link_req_write), .link_addr(link_addr),
        .link_rd_data(link_rd_data), .link_rd_valid(link_rd_valid), .link_busy(link_busy),
        .alarm_any(alarm_any));
    link_host_model host (
        .clk_link(clk_link), .link_req(link_req), .link_req_write(link_req_write), .link_addr(link_addr),
        .link_rd_data(link_rd_data), .link_rd_valid(link_rd_valid), .link_busy(link_busy));
    alarm_flag_bank #(.CHANNELS(4)) DUT4 (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .cond_high(cond_high), .cond_low(cond_low),
        .clk_link(clk_link4), .link_req(link_req4), .link_req_write(link_req_write4), .link_addr(link_addr4),
        .link_rd_data(link_rd_data4), .link_rd_valid(link_rd_valid4), .link_busy(link_busy4),
        .alarm_any(alarm_any4));
    link_host_model host4 (
        .clk_link(clk_link4), .link_req(link_req4), .link_req_write(link_req_write4), .link_addr(link_addr4),
        .link_rd_data(link_rd_data4), .link_rd_valid(link_rd_valid4), .link_busy(link_busy4));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // about 3000 cycles are needed; over six times that means a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("mismatch timeout: expected end of run, seen cycle %0d", cycles);
            stop_test();
        end
    end

    task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic access(input int four, input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp, input string what);
        logic [DATA_W-1:0] d;
        logic ok;
        if (four) host4.access(wr, a, d, ok);
        else host.access(wr, a, d, ok);
        check({what, " handshake"}, 8'h01, {7'h00, ok});
        if (!wr) check(what, exp, d);
    endtask : access

    task automatic set_cond(input int ch, input int hi, input logic v);
        @(posedge clk_sys);
        if (hi != 0) cond_high[ch] <= v;
        else cond_low[ch] <= v;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : set_cond

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    initial begin
        logic [ADDR_W-1:0] a, trip_a, live_a;
        logic [DATA_W-1:0] bitv, exp4;
        clk_en = 1'b1;
        cond_high = '0;
        cond_low = '0;
        reset_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;

        // map edges and reset values; unmapped neighbours read zero
        for (a = 7'h0f; a <= 7'h15; a++) begin
            exp4 = (a == 7'h10) ? 8'hf0 : ((a == 7'h13 || a == 7'h14) ? 8'hff : 8'h00);
            access(0, 1'b0, a, 8'h00, "reset value");
            access(1, 1'b0, a, exp4, "four-channel value");
        end
        access(1, 1'b1, ADDR_TRIP_HI, 8'h00, "four-channel write");
        access(1, 1'b1, ADDR_LIVE_HI, 8'h00, "four-channel write");
        access(1, 1'b0, ADDR_TRIP_HI, 8'hff, "upper tripped after write");
        access(1, 1'b0, ADDR_LIVE_HI, 8'hff, "upper active after write");
        end_test("reset and map");

        // one flag at a time: position, live following, latching, summary, clear on read
        for (int ch = 0; ch < 8; ch++) begin
            for (int hi = 0; hi < 2; hi++) begin
                bitv = 8'h80 >> (2 * (ch % 4) + hi);
                trip_a = (ch < 4) ? ADDR_TRIP_LO : ADDR_TRIP_HI;
                live_a = (ch < 4) ? ADDR_LIVE_LO : ADDR_LIVE_HI;
                set_cond(ch, hi, 1'b1);
                check("alarm level", 8'h01, {7'h00, alarm_any});
                check("four-channel alarm level", {7'h00, ch < 4}, {7'h00, alarm_any4});
                access(0, 1'b0, live_a, bitv, "active flag");
                set_cond(ch, hi, 1'b0);
                access(0, 1'b0, live_a, 8'h00, "active after end");
                access(0, 1'b0, ADDR_SUMMARY, 8'h01 << ch, "summary");
                access(0, 1'b0, trip_a, bitv, "tripped flag");
                access(0, 1'b0, trip_a, 8'h00, "tripped after read");
                check("alarm level after read", 8'h00, {7'h00, alarm_any});
                if (ch < 4) access(1, 1'b0, trip_a, bitv, "four-channel tripped");
                check("four-channel alarm after read", 8'h00, {7'h00, alarm_any4});
            end
        end
        end_test("flag map");

        // a read during a standing alarm must not lose the flag; writes never clear
        set_cond(0, 0, 1'b1);
        access(0, 1'b0, ADDR_TRIP_LO, 8'h80, "tripped while present");
        access(0, 1'b0, ADDR_TRIP_LO, 8'h80, "tripped kept by set");
        set_cond(0, 0, 1'b0);
        access(0, 1'b1, ADDR_TRIP_LO, 8'h00, "write to tripped");
        access(0, 1'b0, ADDR_TRIP_LO, 8'h80, "tripped after write");
        access(0, 1'b0, ADDR_TRIP_LO, 8'h00, "tripped cleared");
        end_test("set wins clear");

        // clock enable low freezes the flags
        @(posedge clk_sys);
        clk_en <= 1'b0;
        set_cond(2, 1, 1'b1);
        check("alarm level frozen", 8'h00, {7'h00, alarm_any});
        @(posedge clk_sys);
        clk_en <= 1'b1;
        set_cond(2, 1, 1'b0);
        check("alarm level after enable", 8'h01, {7'h00, alarm_any});
        access(0, 1'b0, ADDR_TRIP_LO, 8'h04, "tripped after enable");
        end_test("clock enable");

        stop_test();
    end
endmodule : test_alarm_flag_bank
